// ===== rtl/pdh_decode.v
/*
  Combinational decode of one port descriptor word into the role and
  policy bits the handler acts on.
  Assumes the word is stable while the handler samples the outputs.
*/
`include "pdh_map.vh"
`default_nettype none

module pdh_decode (
  input  wire [15:0] desc,
  input  wire [3:0]  rx_fcode,
  output wire        active_source,
  output wire        active_sink,
  output wire        check_seq_transfer_en,
  output wire        write_always_en,
  output wire        queue_attach,
  output wire [2:0]  transfer_irq_select,
  output wire        fcode_match
);

  // ******************************************************
  // Field decode
  // ******************************************************
  // source bit dominates
  assign active_source = desc[`PDH_SRC_BIT];
  assign active_sink = desc[`PDH_SINK_BIT] & ~desc[`PDH_SRC_BIT];
  assign check_seq_transfer_en = desc[`PDH_CSEQ_BIT];
  assign write_always_en = desc[`PDH_WRALL_BIT];
  assign queue_attach = desc[`PDH_QA_BIT];
  assign transfer_irq_select = desc[`PDH_IRQSEL_HI:`PDH_IRQSEL_LO];
  assign fcode_match = (desc[`PDH_FCODE_HI:`PDH_FCODE_LO] == rx_fcode);

endmodule

`default_nettype wire

// ===== rtl/pdh_map.vh
/*
  Constants of the port descriptor handler: descriptor word fields,
  function codes, register offsets and reset values.
  Assumes it is included by bare name after the header comment.
*/
`ifndef PDH_MAP_VH
`define PDH_MAP_VH

// ******************************************************
// Descriptor word 0 field positions
// ******************************************************
`define PDH_FCODE_HI      15
`define PDH_FCODE_LO      12
`define PDH_SRC_BIT       11
`define PDH_SINK_BIT      10
`define PDH_CSEQ_BIT      9
`define PDH_WRALL_BIT     8
`define PDH_IRQSEL_HI     7
`define PDH_IRQSEL_LO     5
`define PDH_QA_BIT        2

// ******************************************************
// Codes
// ******************************************************
`define PDH_FCODE_MSG     4'h0_00c
`define PDH_IRQSEL_NONE   3'h0_0
`define PDH_IRQSEL_CMP    3'h0_7

// ******************************************************
// Register byte offsets
// ******************************************************
`define PDH_OFS_CTRL      12'h0_000
`define PDH_OFS_STATUS    12'h0_004
`define PDH_OFS_MASK      12'h0_008
`define PDH_OFS_STATE     12'h0_00c
`define PDH_OFS_DISCARD   12'h0_010

// ******************************************************
// Status bit positions and reset values
// ******************************************************
`define PDH_ST_DISCARD    7
`define PDH_ST_FMISS      8
`define PDH_CTRL_RST      1'h1
`define PDH_MASK_RST      9'h0_000
`define PDH_STATUS_RST    9'h0_000
`define PDH_DESC_RST      16'h0_000

`endif

// ===== rtl/pdh_top.v
/*
  Port descriptor handler: interprets the descriptor word of the port
  selected by a master frame, decides whether the slave frame is stored,
  moves the check sequence to or from descriptor word 3, and raises the
  selected data-transfer interrupt line. APB slave for control/status.
  Assumes frame logic and traffic memory logic run on pclk, so their
  strobes need no synchroniser; strobes are one-cycle pulses.
*/
//
// Function
// - Active sink needs sink bit 1 and source bit 0, else passive sink.
// - Check-sequence bit moves an 8-bit check sequence via descriptor word 3.
// - Queued messages keep check sequences in the descriptor, not the queue.
// - Write-always 0: erroneous slave frame not stored, queued, or paged.
// - Write-always 1: store correct and size-consistent erroneous frames.
// - Frames with size mismatch are always discarded.
// - Interrupt only after successful processing or stored recoverable data.
// - Interrupt select 000 gives no data-transfer interrupt.
// - Select 001 to 101 raise lines 1 to 5.
// - Select 110 raises 6; 111 sink compares, source silent, no line 7.
// - Source bit 1 makes an active source whatever the sink bit.
// - Descriptor read on each port selection; act only on equal code (captured only when idle with ctrl_en set).
`include "pdh_map.vh"
`default_nettype none

module pdh_top (
  input  wire        pclk,
  input  wire        presetn,
  // APB slave
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  output reg         irq,
  // Master frame side
  input  wire        port_select,
  input  wire [3:0]  rx_fcode,
  input  wire [15:0] port_descriptor,
  // Slave frame side
  input  wire        sf_done,
  input  wire        sf_error,
  input  wire        sf_size_bad,
  input  wire [7:0]  sf_check_seq,
  input  wire        sf_timeout,
  input  wire        tx_done,
  // Traffic memory actions
  output reg         data_store,
  output reg         queue_append,
  output reg         valid_page_flip,
  output reg         cs_store,
  output reg  [7:0]  cs_store_data,
  output reg         cs_load,
  output reg         auto_compare,
  output reg  [6:0]  transfer_done_irq
);

  // ******************************************************
  // State machine codes
  // ******************************************************
  localparam ST_IDLE = 2'd0;
  localparam ST_SINK = 2'd1;
  localparam ST_SRC  = 2'd2;

  reg  [1:0]  state;
  reg  [1:0]  next_state;
  reg  [15:0] desc;
  reg  [3:0]  fcode;
  reg         ctrl_en;
  reg  [8:0]  irq_mask;
  reg  [8:0]  irq_status;
  reg  [8:0]  rd_snap;
  reg         rd_status;
  reg  [15:0] discard_cnt;

  wire        dec_src;
  wire        dec_sink;
  wire        dec_cseq;
  wire        dec_wrall;
  wire        dec_qa;
  wire [2:0]  dec_sel;
  wire        dec_match;
  wire        new_src;
  wire        new_sink;
  wire        new_match;

  // Live decode of the incoming word at selection time
  pdh_decode u_new (
    .desc                  (port_descriptor),
    .rx_fcode              (rx_fcode),
    .active_source         (new_src),
    .active_sink           (new_sink),
    .check_seq_transfer_en (),
    .write_always_en       (),
    .queue_attach          (),
    .transfer_irq_select   (),
    .fcode_match           (new_match)
  );

  // Decode of the captured word for the rest of the transfer
  pdh_decode u_held (
    .desc                  (desc),
    .rx_fcode              (fcode),
    .active_source         (dec_src),
    .active_sink           (dec_sink),
    .check_seq_transfer_en (dec_cseq),
    .write_always_en       (dec_wrall),
    .queue_attach          (dec_qa),
    .transfer_irq_select   (dec_sel),
    .fcode_match           (dec_match)
  );

  // ******************************************************
  // Interrupt line decode
  // ******************************************************
  // One-hot line for a select value; 111 on a sink gives no line
  function [6:0] line_of;
    input [2:0] sel;
    input       sink;
    begin
      line_of = 7'h0_0;
      if (sel != `PDH_IRQSEL_NONE &&
          !(sel == `PDH_IRQSEL_CMP && sink)) begin
        line_of[sel - 3'd1] = 1'b1;
      end
    end
  endfunction

  // ******************************************************
  // Slave frame decision
  // ******************************************************
  wire sel_ok   = port_select & ctrl_en;
  wire sink_end = (state == ST_SINK) & sf_done;
  wire keep     = ~sf_size_bad & (~sf_error | dec_wrall);
  wire stored   = sink_end & keep;
  wire dropped  = sink_end & ~keep;
  wire is_msgq  = dec_qa & (fcode == `PDH_FCODE_MSG);
  wire src_end  = (state == ST_SRC) & tx_done;

  // Next state; a new selection only counts when idle
  always @* begin
    next_state = state;
    case (state)
      ST_IDLE: begin
        if (sel_ok && new_match) begin
          if (new_src) begin
            next_state = ST_SRC;
          end else if (new_sink) begin
            next_state = ST_SINK;
          end
        end
      end
      ST_SINK: begin
        if (sf_done || sf_timeout) begin
          next_state = ST_IDLE;
        end
      end
      ST_SRC: begin
        if (tx_done || sf_timeout) begin
          next_state = ST_IDLE;
        end
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  // Descriptor capture and state register
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= ST_IDLE;
      desc  <= `PDH_DESC_RST;
      fcode <= 4'h0;
    end else begin
      state <= next_state;
      if (state == ST_IDLE && sel_ok) begin
        desc  <= port_descriptor;
        fcode <= rx_fcode;
      end
    end
  end

  // ******************************************************
  // Traffic memory strobes and interrupt lines
  // ******************************************************
  // Every strobe is registered so the memory side sees clean pulses
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      data_store        <= 1'b0;
      queue_append      <= 1'b0;
      valid_page_flip   <= 1'b0;
      cs_store          <= 1'b0;
      cs_store_data     <= 8'h00;
      cs_load           <= 1'b0;
      auto_compare      <= 1'b0;
      transfer_done_irq <= 7'h0_0;
    end else begin
      // no write, queue or page change when not kept
      data_store      <= stored & ~is_msgq;
      queue_append    <= stored & is_msgq;
      valid_page_flip <= stored & ~is_msgq;
      // check sequence stored in word 3
      // also when queued, never into the queue
      cs_store        <= stored & dec_cseq;
      if (stored && dec_cseq) begin
        cs_store_data <= sf_check_seq;
      end
      // source loads its check sequence from word 3
      cs_load <= (state == ST_IDLE) & sel_ok & new_match & new_src &
                 port_descriptor[`PDH_CSEQ_BIT];
      // 111 on a sink starts the comparison
      auto_compare <= stored & (dec_sel == `PDH_IRQSEL_CMP);
      if (stored) begin
        transfer_done_irq <= line_of(dec_sel, 1'b1);
      end else if (src_end) begin
        transfer_done_irq <= line_of(dec_sel, 1'b0) &
                             {(dec_sel != `PDH_IRQSEL_CMP), 6'h3f};
      end else begin
        transfer_done_irq <= 7'h0_0;
      end
    end
  end

  // ******************************************************
  // APB slave
  // ******************************************************
  wire setup  = psel & ~penable;
  wire commit = psel & penable & pready;
  wire [8:0] ev_set = {
    (state == ST_IDLE) & sel_ok & ~new_match,
    dropped,
    (stored ? line_of(dec_sel, 1'b1) : 7'h0_0) |
    (src_end ? (line_of(dec_sel, 1'b0) &
                {(dec_sel != `PDH_IRQSEL_CMP), 6'h3f}) : 7'h0_0)
  };

  // Address decode, used only for the error answer; read data uses its own case
  function mapped;
    input [11:0] a;
    begin
      mapped = (a == `PDH_OFS_CTRL)  || (a == `PDH_OFS_STATUS) ||
               (a == `PDH_OFS_MASK)  || (a == `PDH_OFS_STATE)  ||
               (a == `PDH_OFS_DISCARD);
    end
  endfunction

  // One wait-free access cycle; data is snapshotted at setup
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready    <= 1'b0;
      pslverr   <= 1'b0;
      prdata    <= 32'h0000_0000;
      rd_snap   <= 9'h0_00;
      rd_status <= 1'b0;
    end else begin
      pready  <= setup;
      pslverr <= setup & ~mapped(paddr);
      if (setup) begin
        rd_status <= ~pwrite & (paddr == `PDH_OFS_STATUS);
        rd_snap   <= irq_status;
        case (paddr)
          `PDH_OFS_CTRL:    prdata <= {31'h0, ctrl_en};
          `PDH_OFS_STATUS:  prdata <= {23'h0, irq_status};
          `PDH_OFS_MASK:    prdata <= {23'h0, irq_mask};
          `PDH_OFS_STATE:   prdata <= {10'h0, state, dec_src, dec_sink,
                                       2'b00, desc};
          `PDH_OFS_DISCARD: prdata <= {16'h0, discard_cnt};
          default:          prdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  // Control registers; read-clear drops only bits the read returned
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_en     <= `PDH_CTRL_RST;
      irq_mask    <= `PDH_MASK_RST;
      irq_status  <= `PDH_STATUS_RST;
      discard_cnt <= 16'h0000;
      irq         <= 1'b0;
    end else begin
      if (commit && pwrite && paddr == `PDH_OFS_CTRL) begin
        ctrl_en <= pwdata[0];
      end
      if (commit && pwrite && paddr == `PDH_OFS_MASK) begin
        irq_mask <= pwdata[8:0];
      end
      // Set wins over the read clear
      if (commit && rd_status) begin
        irq_status <= (irq_status & ~rd_snap) | ev_set;
      end else begin
        irq_status <= irq_status | ev_set;
      end
      if (dropped && discard_cnt != 16'hffff) begin
        discard_cnt <= discard_cnt + 16'h0001;
      end
      irq <= |(irq_status & irq_mask);
    end
  end

endmodule

`default_nettype wire

// ===== sim/pdh_assertions.sv
/* Checker on pdh_top ports; a copy of the last descriptor is kept.
   Assumes one pclk domain and the bind at the foot. */
`include "pdh_map.vh"
`default_nettype none
module pdh_assertions (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        port_select,
  input wire logic [15:0] port_descriptor,
  input wire logic [3:0]  rx_fcode,
  input wire logic        sf_done,
  input wire logic        sf_error,
  input wire logic        sf_size_bad,
  input wire logic [7:0]  sf_check_seq,
  input wire logic        tx_done,
  input wire logic        data_store,
  input wire logic        queue_append,
  input wire logic        valid_page_flip,
  input wire logic        cs_store,
  input wire logic [7:0]  cs_store_data,
  input wire logic        cs_load,
  input wire logic        auto_compare,
  input wire logic [6:0]  transfer_done_irq
);
  logic [15:0] d_q;
  logic [3:0]  f_q;
  wire  [2:0]  s_q = d_q[`PDH_IRQSEL_HI:`PDH_IRQSEL_LO];
  // Descriptor of the last selection, seen while the port is served
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin d_q <= '0; f_q <= '0; end
    else if (port_select) begin d_q <= port_descriptor; f_q <= rx_fcode; end
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  sink_role_a: assert property (data_store |->
    !d_q[`PDH_SRC_BIT] && d_q[`PDH_SINK_BIT]) else $error("store off sink");
  cs_data_a: assert property (cs_store |-> d_q[`PDH_CSEQ_BIT] &&
    cs_store_data == $past(sf_check_seq)) else $error("check seq wrong");
  err_store_a: assert property (data_store && $past(sf_error) |->
    d_q[`PDH_WRALL_BIT]) else $error("erroneous frame stored");
  size_bad_a: assert property ((data_store || queue_append) |->
    $past(sf_done) && !$past(sf_size_bad)) else $error("bad size stored");
  line_cause_a: assert property (|transfer_done_irq |->
    $past(sf_done) || $past(tx_done)) else $error("line without transfer");
  line_map_a: assert property (|transfer_done_irq |->
    s_q != 3'h7 &&
    transfer_done_irq == (7'h01 << (s_q - 3'h1))) else $error("wrong line");
  // A queued sink also compares, so either store strobe qualifies
  cmp_sink_a: assert property (auto_compare |-> s_q == 3'h7 &&
    d_q[`PDH_SINK_BIT] && !d_q[`PDH_SRC_BIT] &&
    (data_store || queue_append)) else $error("compare misplaced");
  fcode_eq_a: assert property (data_store |->
    d_q[`PDH_FCODE_HI:`PDH_FCODE_LO] == f_q) else $error("code mismatch");
  load_src_a: assert property (cs_load |->
    $past(port_select) &&
    $past(port_descriptor[`PDH_SRC_BIT])) else $error("load off source");
  queue_page_a: assert property (queue_append |-> !valid_page_flip)
    else $error("page flipped on queue");
  cover property (data_store && $past(sf_error));
  cover property (cs_load);
  cover property (auto_compare);
endmodule
bind pdh_top pdh_assertions u_chk (.pclk(pclk), .presetn(presetn),
  .port_select(port_select), .port_descriptor(port_descriptor),
  .rx_fcode(rx_fcode), .sf_done(sf_done), .sf_error(sf_error),
  .sf_size_bad(sf_size_bad), .sf_check_seq(sf_check_seq),
  .tx_done(tx_done), .data_store(data_store), .queue_append(queue_append),
  .valid_page_flip(valid_page_flip), .cs_store(cs_store),
  .cs_store_data(cs_store_data), .cs_load(cs_load),
  .auto_compare(auto_compare), .transfer_done_irq(transfer_done_irq));
`default_nettype wire

// ===== sim/pdh_bus_model.sv
/* Frame-side partner: master frame selects a port, then slave frame or
   transmit end. Assumes the bench calls its tasks after a pclk edge. */
`default_nettype none
module pdh_bus_model (
  input  wire logic       pclk,
  output var  logic       port_select,
  output var  logic [3:0] rx_fcode,
  output var  logic [15:0] port_descriptor,
  output var  logic       sf_done,
  output var  logic       sf_error,
  output var  logic       sf_size_bad,
  output var  logic [7:0] sf_check_seq,
  output var  logic       sf_timeout,
  output var  logic       tx_done
);
  initial begin
    {port_select, rx_fcode, port_descriptor, sf_done, sf_error} = '0;
    {sf_size_bad, sf_check_seq, sf_timeout, tx_done} = '0;
  end
  // descriptor set up by software
  // Lines are inverted once released so stale values never look valid
  task automatic sel(input logic [15:0] d, input logic [3:0] f);
    @(posedge pclk) begin port_select <= 1; port_descriptor <= d; end
    rx_fcode <= f;
    @(posedge pclk) begin port_select <= 0; port_descriptor <= ~d; end
    rx_fcode <= ~f;
  endtask
  // Slave frame end, or a timeout that abandons it
  task automatic frame(input logic e, b, to, input logic [7:0] c);
    @(posedge pclk) begin sf_done <= !to; sf_timeout <= to; end
    {sf_error, sf_size_bad, sf_check_seq} <= {e, b, c};
    @(posedge pclk) begin sf_done <= 0; sf_timeout <= 0; end
    {sf_error, sf_size_bad, sf_check_seq} <= ~{e, b, c};
  endtask
  task automatic tx;
    @(posedge pclk) tx_done <= 1;
    @(posedge pclk) tx_done <= 0;
  endtask
endmodule
`default_nettype wire

// ===== sim/test_port_descriptor_handling.sv
/* Bench: random descriptors and frames against a behavioural model.
   Assumes pdh_top, pdh_bus_model and the bound checker. */
`include "pdh_map.vh"
`default_nettype none
module test_port_descriptor_handling;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, r;
  logic pready, pslverr, irq, ps, sd, se, sb, st, td, ds, qa, pgf, cs, ld, ac;
  logic clr = 0;
  logic [3:0] rf, f;
  logic [15:0] pd, d;
  logic [7:0] sc, csd, cs_got, c;
  logic [6:0] tdl;
  logic [12:0] seen = '0, ex;
  logic [31:0] est;
  int n_fail = 0, comparisons = 0, cyc = 0, dsc = 0, s;
  logic en, e, b, to, er, ok;
  always #2 pclk = ~pclk;
  pdh_top dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq),
    .port_select(ps), .rx_fcode(rf), .port_descriptor(pd), .sf_done(sd),
    .sf_error(se), .sf_size_bad(sb), .sf_check_seq(sc), .sf_timeout(st),
    .tx_done(td), .data_store(ds), .queue_append(qa),
    .valid_page_flip(pgf), .cs_store(cs), .cs_store_data(csd),
    .cs_load(ld), .auto_compare(ac), .transfer_done_irq(tdl));
  pdh_bus_model u_bus (.pclk(pclk), .port_select(ps), .rx_fcode(rf),
    .port_descriptor(pd), .sf_done(sd), .sf_error(se), .sf_size_bad(sb),
    .sf_check_seq(sc), .sf_timeout(st), .tx_done(td));
  // Sticky record of strobes; one-cycle pulses are never missed
  always @(posedge pclk) begin
    if (clr) seen <= '0;
    else seen <= seen | {ac, ld, cs, pgf, qa, ds | qa, tdl};
    if (cs) cs_got <= csd;
    cyc <= cyc + 1;
    if (cyc == 8000) begin n_fail++; final_report; end
  end
  task automatic chk(input logic [31:0] g, x);
    comparisons++;
    if (g !== x) begin
      $display("ERROR t=%0t got=%h exp=%h", $time, g, x);
      n_fail++;
    end
  endtask
  // APB transfer; held until pready is sampled high
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] wd);
    @(posedge pclk);
    {psel, penable, pwrite} <= {2'b10, w};
    {paddr, pwdata} <= {a, wd};
    @(posedge pclk) penable <= 1;
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata;
    er = pslverr;
    {psel, penable} <= 2'b00;
  endtask
  task automatic final_report;
    if (n_fail == 0 && comparisons > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  initial begin
    void'($urandom(32'hee35cd95));
    repeat (16) @(posedge pclk);
    presetn <= 1;
    apb(0, `PDH_OFS_CTRL, 0);
    chk(r, 32'h0000_0001);
    apb(0, `PDH_OFS_MASK, 0);
    chk(r, 32'h0000_0000);
    apb(1, 12'h014, 32'hffff_ffff);
    chk({r[30:0], er}, 32'h0000_0001);
    // A sink waiting for its slave frame shows in the state register
    u_bus.sel(16'h3400, 4'h3);
    apb(0, `PDH_OFS_STATE, 0);
    chk(r, 32'h0014_3400);
    u_bus.frame(0, 0, 1, 8'h00);
    for (int i = 0; i < 80; i++) begin
      if (i % 40 == 0) apb(1, `PDH_OFS_MASK, i ? 32'h0000_01ff : 32'h0);
      en = i % 10 != 9;
      apb(1, `PDH_OFS_CTRL, {31'h0, en});
      f = ($urandom % 3 == 0) ? 4'hc : 4'($urandom);
      d = 16'($urandom);
      if ($urandom % 4) d[15:12] = f;
      {e, b, to, c} = {$urandom % 3 == 0, $urandom % 5 == 0,
                       $urandom % 8 == 0, 8'($urandom)};
      // Model: roles, store policy, check sequence, line select
      s = d[7:5];
      ex = '0;
      est = '0;
      ok = 0;
      if (en && d[15:12] != f) est[8] = 1;
      else if (en && d[11]) begin ex[11] = d[9]; ok = 1; end
      else if (en && d[10] && !to) begin
        if (!b && (!e || d[8])) begin
          ok = 1;
          ex[8] = d[2] && f == 4'hc;
          ex[12:7] = {s == 7, 1'b0, d[9], !ex[8], ex[8], 1'b1};
        end else begin est[7] = 1; dsc++; end
      end
      if (ok && s != 0 && s != 7) begin ex[s - 1] = 1; est[s - 1] = 1; end
      // Clear the strobe record while the frame side is idle
      clr <= 1;
      @(posedge pclk);
      clr <= 0;
      u_bus.sel(d, f);
      if (en && d[15:12] == f && d[11]) u_bus.tx;
      else if (en && d[15:12] == f && d[10]) u_bus.frame(e, b, to, c);
      repeat (4) @(posedge pclk);
      chk(seen, ex);
      chk(seen[11], ex[11]);
      if (ex[10]) chk(cs_got, c);
      chk(irq, i >= 40 && est != 0);
      apb(0, `PDH_OFS_STATUS, 0);
      chk(r, est);
      repeat (3) @(posedge pclk);
      chk(irq, 0);
    end
    apb(0, `PDH_OFS_DISCARD, 0);
    chk(r, dsc);
    final_report;
  end
endmodule
`default_nettype wire
